/* design/iscs_pkg.sv */
// Package with register map, field positions, reset values and carrier types of the status/clock/frame block
package iscs_pkg;
	// -------------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] OFF_CTL0 = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h10;
	localparam logic [7:0] OFF_STAT0 = 8'h14;
	localparam logic [7:0] OFF_STAT1 = 8'h18;
	localparam logic [7:0] OFF_CKCFG = 8'h1c;
	localparam logic [7:0] OFF_RT = 8'h20;
	localparam logic [7:0] OFF_SAMCS = 8'h80;
	// -------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------
	localparam int CTL0_EN = 0;
	localparam int CTL0_PECEN = 5;
	localparam int CTL0_STRETCH_DIS = 7;
	localparam int ST0_START = 0;
	localparam int ST0_ADDR = 1;
	localparam int ST0_BTC = 2;
	localparam int ST0_HDR10 = 3;
	localparam int ST0_ARBLOST = 9;
	localparam int ST1_MASTER = 0;
	localparam int ST1_BUSY = 1;
	localparam int ST1_TRS = 2;
	localparam int ST1_GC = 4;
	localparam int ST1_DEF = 5;
	localparam int ST1_HOST = 6;
	localparam int ST1_DUAL = 7;
	localparam int CK_FAST = 15;
	localparam int CK_DUTY = 14;
	localparam int SAM_FLAG_LO = 12;
	localparam int SAM_RXL = 9;
	localparam int SAM_TXL = 8;
	localparam int SAM_IE_LO = 4;
	localparam int SAM_TOEN = 1;
	localparam int SAM_EN = 0;
	// -------------------------------------------------------------------
	// Reset values and counts
	// -------------------------------------------------------------------
	localparam logic [5:0] RT_RESET = 6'h02;
	localparam logic [15:0] FAST_HI_MULT = 16'h0001;
	localparam logic [15:0] FAST_LO_MULT = 16'h0002;
	localparam logic [15:0] DUTY_HI_MULT = 16'h0009;
	localparam logic [15:0] DUTY_LO_MULT = 16'h0010;
	localparam logic [11:0] FRAME_TIMEOUT_CYC = 12'hfa0;
	// -------------------------------------------------------------------
	// Carrier types
	// -------------------------------------------------------------------
	typedef struct packed {
		logic start_sent;
		logic hdr10_sent;
		logic addr_sent;
		logic addr_match;
		logic match_second;
		logic match_host;
		logic match_default;
		logic match_gencall;
		logic transmitter;
		logic arb_lost;
		logic rx_mode;
		logic shift_full;
		logic shift_empty;
		logic data_full;
		logic data_empty;
	} iscs_evt_t;
	typedef struct packed {
		logic enable;
		logic pec_en;
		logic stretch_dis;
		logic fast;
		logic duty;
		logic [11:0] clock_control_value;
		logic [5:0] rise_time;
		logic frame_en;
		logic frame_timeout_en;
	} iscs_cfg_t;
endpackage : iscs_pkg

/* design/iscs_regs.sv */
// Status, clock configuration, rise time and frame side-band registers of the two-wire controller
// Notes on behaviour
// - Ten-bit header flag set when sent; cleared by status zero read then data write.
// - With stretching, byte-complete sets on rx shift+data full or tx both empty.
// - Byte-complete clears on status zero read plus data access, START/STOP, disable.
// - Address flag set on sent/matched address; cleared by status zero then one read.
// - Start-sent flag set after START; cleared by status zero read then data write.
// - With check enabled, computed check value shows in status one upper byte.
// - Dual flag tells which own address matched; clears on STOP, START, disable.
// - Host header flag set on host header in slave; clears on STOP, START, disable.
// - Default address flag set on SMBus default address; clears on STOP, START, disable.
// - General call flag set on address zero; clears on STOP, START, disable.
// - Transmitter bit shows direction; clears on STOP, START, disable, arbitration loss.
// - Busy bit high while bus active, cleared only by STOP.
// - Master bit shows role; clears on STOP, START, disable, arbitration loss.
// - Clock register bit 15 picks standard or fast speed in master mode.
// - Standard speed: SCL high and low each last clock value pclk periods.
// - Fast: high 1x, low 2x clock value; with duty bit, high 9x, low 16x.
// - Rise and fall flags per frame signal; software clears each by writing 0.
// - Current receive and transmit frame levels readable at bits 9 and 8.
// - Four interrupt enables, one per frame edge flag, at bits 7 to 4.
// - Bit 1 enables frame timeout detection, bit 0 enables frame interface.
// - Control bit 0 enables the controller; disable clears the status flags except busy and the arbitration loss flag.
// - Arbitration loss sets its error flag and returns the block to slave.
`timescale 1ns/1ns
module iscs_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire iscs_pkg::iscs_evt_t evt,
	input wire logic [7:0] pec_value,
	input wire logic [7:0] data_rd_value,
	input wire logic scl_gen_en,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic rx_frame_in,
	input wire logic tx_frame_in,
	output logic scl_out,
	output logic scl_oe,
	output iscs_pkg::iscs_cfg_t cfg,
	output logic data_wr,
	output logic [7:0] data_wr_value,
	output logic data_rd,
	output logic frame_timeout,
	output logic irq
);
	// -------------------------------------------------------------------
	// Bus access decode
	// -------------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	logic acc;
	logic mapped;
	logic rd_stat0, rd_stat1, rd_data, wr_data;
	assign acc = ce & psel & penable & pready;
	assign mapped = hit(paddr, iscs_pkg::OFF_CTL0) | hit(paddr, iscs_pkg::OFF_DATA) | hit(paddr, iscs_pkg::OFF_STAT0)
		| hit(paddr, iscs_pkg::OFF_STAT1) | hit(paddr, iscs_pkg::OFF_CKCFG) | hit(paddr, iscs_pkg::OFF_RT)
		| hit(paddr, iscs_pkg::OFF_SAMCS);
	assign rd_stat0 = acc & ~pwrite & hit(paddr, iscs_pkg::OFF_STAT0);
	assign rd_stat1 = acc & ~pwrite & hit(paddr, iscs_pkg::OFF_STAT1);
	assign rd_data = acc & ~pwrite & hit(paddr, iscs_pkg::OFF_DATA);
	assign wr_data = acc & pwrite & hit(paddr, iscs_pkg::OFF_DATA);

	// -------------------------------------------------------------------
	// Pin synchronisers and bus condition detection
	// -------------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] sync1, sync2, sync3;
	assign pin_raw = {tx_frame_in, rx_frame_in, sda_in, scl_in};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sync1[gi] <= 1'b1;
					sync2[gi] <= 1'b1;
					sync3[gi] <= 1'b1;
				end
				else if (ce)
				begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
				end
			end
		end
	endgenerate

	logic start_det, stop_det, cond_det;
	// Data line moving while the clock line stays high marks a START or STOP
	assign start_det = ce & sync2[0] & sync3[0] & sync3[1] & ~sync2[1];
	assign stop_det = ce & sync2[0] & sync3[0] & ~sync3[1] & sync2[1];
	assign cond_det = start_det | stop_det;

	// -------------------------------------------------------------------
	// Control and configuration registers
	// -------------------------------------------------------------------
	logic en;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg <= '0;
		else if (acc && pwrite)
		begin
			if (hit(paddr, iscs_pkg::OFF_CTL0))
			begin
				cfg.enable <= pwdata[iscs_pkg::CTL0_EN];
				cfg.pec_en <= pwdata[iscs_pkg::CTL0_PECEN];
				cfg.stretch_dis <= pwdata[iscs_pkg::CTL0_STRETCH_DIS];
			end
			if (hit(paddr, iscs_pkg::OFF_CKCFG))
			begin
				cfg.fast <= pwdata[iscs_pkg::CK_FAST];
				cfg.duty <= pwdata[iscs_pkg::CK_DUTY];
				cfg.clock_control_value <= pwdata[11:0];
			end
			if (hit(paddr, iscs_pkg::OFF_SAMCS))
			begin
				cfg.frame_timeout_en <= pwdata[iscs_pkg::SAM_TOEN];
				cfg.frame_en <= pwdata[iscs_pkg::SAM_EN];
			end
		end
	end
	assign en = cfg.enable;

	// Rise time is only held for read-back, the SCL generator does not use it; its reset value is not zero
	logic [5:0] rise_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rise_q <= iscs_pkg::RT_RESET;
		else if (acc && pwrite && hit(paddr, iscs_pkg::OFF_RT))
			rise_q <= pwdata[5:0];
	end

	// -------------------------------------------------------------------
	// Status register zero
	// -------------------------------------------------------------------
	// A read of status zero arms the clear; the next status one or data access fires it
	logic seq_pend;
	logic start_flag, addr_flag, btc_flag, hdr10_flag, arb_flag;
	logic btc_set;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seq_pend <= 1'b0;
		else if (rd_stat0)
			seq_pend <= 1'b1;
		else if (rd_stat1 || rd_data || wr_data)
			seq_pend <= 1'b0;
	end

	assign btc_set = en & ~cfg.stretch_dis & ((evt.rx_mode & evt.shift_full & evt.data_full)
		| (~evt.rx_mode & evt.shift_empty & evt.data_empty));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			start_flag <= 1'b0;
			addr_flag <= 1'b0;
			btc_flag <= 1'b0;
			hdr10_flag <= 1'b0;
			arb_flag <= 1'b0;
		end
		else if (ce)
		begin
			// Disabling drops every flag except arb_flag; otherwise a set in the same cycle beats a clear
			start_flag <= en & ((evt.start_sent) | (start_flag & ~(seq_pend & wr_data)));
			hdr10_flag <= en & ((evt.hdr10_sent) | (hdr10_flag & ~(seq_pend & wr_data)));
			addr_flag <= en & ((evt.addr_sent | evt.addr_match) | (addr_flag & ~(seq_pend & rd_stat1)));
			btc_flag <= btc_set | (en & btc_flag & ~cond_det & ~(seq_pend & (rd_data | wr_data)));
			if (evt.arb_lost)
				arb_flag <= 1'b1;
			else if (acc && pwrite && hit(paddr, iscs_pkg::OFF_STAT0) && !pwdata[iscs_pkg::ST0_ARBLOST])
				arb_flag <= 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// Status register one
	// -------------------------------------------------------------------
	logic master_q, busy_q, trs_q, gc_q, def_q, host_q, dual_q;
	logic role_clr;
	assign role_clr = cond_det | ~en;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			master_q <= 1'b0;
			trs_q <= 1'b0;
			gc_q <= 1'b0;
			def_q <= 1'b0;
			host_q <= 1'b0;
			dual_q <= 1'b0;
		end
		else if (ce)
		begin
			// Arbitration loss hands the bus back: the block drops to slave receiver
			master_q <= en & ~evt.arb_lost & (evt.start_sent | (master_q & ~cond_det));
			trs_q <= en & ~evt.arb_lost & (evt.transmitter | (trs_q & ~role_clr));
			gc_q <= en & ((evt.addr_match & evt.match_gencall) | (gc_q & ~role_clr));
			def_q <= en & ((evt.addr_match & evt.match_default) | (def_q & ~role_clr));
			host_q <= en & ((evt.addr_match & evt.match_host) | (host_q & ~role_clr));
			if (en && evt.addr_match)
				dual_q <= evt.match_second;
			else if (role_clr)
				dual_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_q <= 1'b0;
		else if (start_det)
			busy_q <= 1'b1;
		else if (stop_det)
			busy_q <= 1'b0;
	end

	// -------------------------------------------------------------------
	// Frame side-band monitor
	// -------------------------------------------------------------------
	// Bit order of edge flags: rx rise, rx fall, tx rise, tx fall (high to low)
	logic [3:0] frame_flag, frame_ie, frame_set;
	logic rx_lvl, tx_lvl;
	assign rx_lvl = sync2[2];
	assign tx_lvl = sync2[3];
	assign frame_set = {4{cfg.frame_en & ce}} & {rx_lvl & ~sync3[2], ~rx_lvl & sync3[2],
		tx_lvl & ~sync3[3], ~tx_lvl & sync3[3]};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frame_flag <= '0;
			frame_ie <= '0;
		end
		else if (ce)
		begin
			if (acc && pwrite && hit(paddr, iscs_pkg::OFF_SAMCS))
			begin
				frame_flag <= frame_set | (frame_flag & pwdata[15:12]);
				frame_ie <= pwdata[7:4];
			end
			else
				frame_flag <= frame_set | frame_flag;
		end
	end

	// A frame level held high too long while the interface is enabled is reported
	logic [11:0] to_cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			to_cnt <= '0;
			frame_timeout <= 1'b0;
		end
		else if (ce)
		begin
			if (!(cfg.frame_en && cfg.frame_timeout_en && (rx_lvl || tx_lvl)))
			begin
				to_cnt <= '0;
				frame_timeout <= 1'b0;
			end
			else if (to_cnt == iscs_pkg::FRAME_TIMEOUT_CYC)
				frame_timeout <= 1'b1;
			else
				to_cnt <= to_cnt + 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else if (ce)
			irq <= |(frame_flag & frame_ie);
	end

	// -------------------------------------------------------------------
	// SCL period generator
	// -------------------------------------------------------------------
	function automatic logic [15:0] half_len(input logic low, input logic fast, input logic duty,
		input logic [11:0] clock_control_value);
		logic [15:0] mult;
		mult = 16'h0001;
		if (fast && duty)
			mult = low ? iscs_pkg::DUTY_LO_MULT : iscs_pkg::DUTY_HI_MULT;
		else if (fast)
			mult = low ? iscs_pkg::FAST_LO_MULT : iscs_pkg::FAST_HI_MULT;
		half_len = 16'(mult * {4'h0, clock_control_value});
	endfunction : half_len

	logic scl_run;
	logic [15:0] scl_cnt;
	logic [15:0] scl_target;
	assign scl_run = scl_gen_en & en & master_q & (cfg.clock_control_value != 12'h000);
	assign scl_target = half_len(scl_oe, cfg.fast, cfg.duty, cfg.clock_control_value);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_cnt <= 16'h0001;
			scl_oe <= 1'b0;
			scl_out <= 1'b0;
		end
		else if (ce)
		begin
			scl_out <= 1'b0;
			if (!scl_run)
			begin
				scl_cnt <= 16'h0001;
				scl_oe <= 1'b0;
			end
			else if (scl_cnt >= scl_target)
			begin
				scl_cnt <= 16'h0001;
				scl_oe <= ~scl_oe;
			end
			else
				scl_cnt <= scl_cnt + 16'h0001;
		end
	end

	// -------------------------------------------------------------------
	// APB answer: one wait state, read data captured with ready
	// -------------------------------------------------------------------
	logic [31:0] next_prdata;
	always_comb
	begin
		next_prdata = '0;
		if (hit(paddr, iscs_pkg::OFF_CTL0))
		begin
			next_prdata[iscs_pkg::CTL0_EN] = cfg.enable;
			next_prdata[iscs_pkg::CTL0_PECEN] = cfg.pec_en;
			next_prdata[iscs_pkg::CTL0_STRETCH_DIS] = cfg.stretch_dis;
		end
		else if (hit(paddr, iscs_pkg::OFF_DATA))
			next_prdata[7:0] = data_rd_value;
		else if (hit(paddr, iscs_pkg::OFF_STAT0))
			next_prdata[9:0] = {arb_flag, 5'h00, hdr10_flag, btc_flag, addr_flag, start_flag};
		else if (hit(paddr, iscs_pkg::OFF_STAT1))
			next_prdata[15:0] = {(cfg.pec_en ? pec_value : 8'h00), dual_q, host_q, def_q, gc_q, 1'b0,
				trs_q, busy_q, master_q};
		else if (hit(paddr, iscs_pkg::OFF_CKCFG))
			next_prdata[15:0] = {cfg.fast, cfg.duty, 2'h0, cfg.clock_control_value};
		else if (hit(paddr, iscs_pkg::OFF_RT))
			next_prdata[5:0] = rise_q;
		else if (hit(paddr, iscs_pkg::OFF_SAMCS))
			next_prdata[15:0] = {frame_flag, 2'h0, rx_lvl, tx_lvl, frame_ie, 2'h0,
				cfg.frame_timeout_en, cfg.frame_en};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else if (ce)
		begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel && penable && !pready && !pwrite)
				prdata <= next_prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			data_wr <= 1'b0;
			data_rd <= 1'b0;
			data_wr_value <= '0;
		end
		else if (ce)
		begin
			data_wr <= wr_data;
			data_rd <= rd_data;
			if (wr_data)
				data_wr_value <= pwdata[7:0];
		end
	end

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_arm;
		rd_stat0 && !rd_stat1 && !rd_data && !wr_data;
	endsequence
	sequence s_fire_wr;
		ce && seq_pend && wr_data && !evt.start_sent && !evt.hdr10_sent;
	endsequence

	// Back-to-back APB transfers put at least three edges between the status read and the data write
	property p_start_clear;
		s_arm ##[3:20] s_fire_wr |=> !start_flag && !hdr10_flag;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start or header flag survived clear");

	property p_addr_clear;
		ce && seq_pend && rd_stat1 && !evt.addr_sent && !evt.addr_match |=> !addr_flag;
	endproperty
	a_addr_clear: assert property (p_addr_clear) else $error("address flag survived clear");

	property p_btc_set;
		ce && btc_set |=> btc_flag;
	endproperty
	a_btc_set: assert property (p_btc_set) else $error("byte complete not set");

	property p_btc_cond_clear;
		ce && cond_det && !btc_set |=> !btc_flag;
	endproperty
	a_btc_cond_clear: assert property (p_btc_cond_clear) else $error("byte complete not cleared");

	property p_busy_stop;
		stop_det |=> !busy_q ##1 (!busy_q || $past(start_det));
	endproperty
	a_busy_stop: assert property (p_busy_stop) else $error("busy not cleared by stop");

	property p_arb_lost;
		ce && en && evt.arb_lost |=> arb_flag && !master_q && !trs_q;
	endproperty
	a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss not handled");

	property p_disable;
		ce && !en |=> !gc_q && !def_q && !host_q && !master_q && !trs_q && !start_flag;
	endproperty
	a_disable: assert property (p_disable) else $error("flags kept while disabled");

	property p_frame_rise;
		ce && cfg.frame_en && rx_lvl && !sync3[2] |=> frame_flag[3] ##1 (frame_flag[3] || $past(acc));
	endproperty
	a_frame_rise: assert property (p_frame_rise) else $error("receive frame rise not flagged");

	property p_irq;
		ce && |(frame_flag & frame_ie) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_scl_toggle;
		ce && scl_run && scl_cnt >= scl_target |=> scl_oe != $past(scl_oe) && scl_cnt == 16'h0001;
	endproperty
	a_scl_toggle: assert property (p_scl_toggle) else $error("SCL phase length wrong");
endmodule : iscs_regs

/* tb/iscs_bus_model.sv */
// Far side model: other bus parties on SCL and SDA, and the frame side-band lines
`timescale 1ns/1ns
module iscs_bus_model
(
	input wire logic scl_oe,
	output logic scl_in,
	output logic sda_in,
	output logic rx_frame_in,
	output logic tx_frame_in
);
	logic sda_d = 1'b1;
	// SCL has a pull-up; the far side leaves it released, so it stands high outside frames
	assign scl_in = ~scl_oe;
	assign sda_in = sda_d;
	initial
	begin
		rx_frame_in = 1'b1;
		tx_frame_in = 1'b1;
	end
	// SDA steps half a 160 ns link period apart, kept clear of rising pclk edges
	// The trailing half period lets the condition pass the synchronisers before the caller moves on
	task start_c;
		#10 sda_d = 1'b1;
		#80 sda_d = 1'b0;
		#80;
	endtask : start_c
	task stop_c;
		#10 sda_d = 1'b0;
		#80 sda_d = 1'b1;
		#80;
	endtask : stop_c
	task set_fr(input logic r, input logic t);
		#5 rx_frame_in = r;
		tx_frame_in = t;
	endtask : set_fr
endmodule : iscs_bus_model

/* tb/test_i2c_status_clock_sam_regs.sv */
// Self-checking bench for the status, clock and frame register block
`timescale 1ns/1ns
module test_i2c_status_clock_sam_regs;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, scl_out, scl_oe, data_wr, data_rd, frame_timeout, irq;
	logic scl_in, sda_in, rx_frame_in, tx_frame_in;
	iscs_pkg::iscs_evt_t evt = '0;
	iscs_pkg::iscs_cfg_t cfg;
	logic [7:0] pec_value = 8'h00;
	logic [7:0] data_rd_value = 8'h00;
	logic [7:0] data_wr_value, b;
	logic scl_gen_en = 1'b0;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] rd, ck, fl, lv, ie;
	logic er;
	int c, hi, lo;
	int mh[3] = '{1, 1, 9};
	int ml[3] = '{1, 2, 16};

	always #10 pclk = ~pclk;

	iscs_regs i_iscs_regs (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .evt, .pec_value, .data_rd_value, .scl_gen_en, .scl_in, .sda_in, .rx_frame_in,
		.tx_frame_in, .scl_out, .scl_oe, .cfg, .data_wr, .data_wr_value, .data_rd, .frame_timeout, .irq);
	iscs_bus_model i_iscs_bus_model (.scl_oe, .scl_in, .sda_in, .rx_frame_in, .tx_frame_in);

	// ----
	// Helpers
	// ----
	task end_of_test;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task tmo;
		error_cnt++;
		$display("ERROR %0t wait ran out", $time);
		end_of_test();
	endtask : tmo
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			tmo();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task pev(input logic [14:0] m);
		@(posedge pclk);
		evt <= iscs_pkg::iscs_evt_t'(m);
		@(posedge pclk);
		evt <= '0;
	endtask : pev
	// Low phase is counted while scl_oe pulls, the released phase after it
	task meas(output int h, output int l);
		int n;
		n = 0;
		while (scl_oe !== 1'b0 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
		while (scl_oe !== 1'b1 && n < 400)
		begin
			@(posedge pclk);
			n++;
		end
		l = 0;
		h = 0;
		while (scl_oe === 1'b1 && l < 200)
		begin
			@(posedge pclk);
			l++;
		end
		while (scl_oe === 1'b0 && h < 200)
		begin
			@(posedge pclk);
			h++;
		end
		if (n >= 400)
			tmo();
	endtask : meas

	// ----
	// Main sequence
	// ----
	initial
	begin
		void'($urandom(32'hdb81));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(iscs_pkg::OFF_STAT1, 32'h0);
		rdc(iscs_pkg::OFF_CKCFG, 32'h0);
		rdc(iscs_pkg::OFF_RT, 32'h2);
		rdc(iscs_pkg::OFF_SAMCS, 32'h300);
		apb(1'b0, 8'h40, 32'h0);
		chk(er, 1'b1);
		// Software loads a random rise time from 1 to 63; reserved bits stay clear
		b = 8'($urandom_range(62, 0)) + 8'd1;
		apb(1'b1, iscs_pkg::OFF_RT, 32'hffffff00 | b);
		rdc(iscs_pkg::OFF_RT, {24'h0, b});
		apb(1'b1, iscs_pkg::OFF_CTL0, 32'h21);
		@(posedge pclk);
		pec_value <= 8'($urandom);
		data_rd_value <= 8'($urandom);
		i_iscs_bus_model.start_c();
		pev(15'h4000);
		for (int i = 0; i < 3; i++)
		begin
			c = $urandom_range(4, 1);
			ck = {16'h0, i > 0, i > 1, 2'b00, 12'(c)};
			apb(1'b1, iscs_pkg::OFF_CKCFG, ck);
			rdc(iscs_pkg::OFF_CKCFG, ck);
			@(posedge pclk);
			scl_gen_en <= 1'b1;
			meas(hi, lo);
			scl_gen_en <= 1'b0;
			chk(scl_out, 1'b0);
			chk(hi, c * mh[i]);
			chk(lo, c * ml[i]);
		end
		pev(15'h0040);
		pev(15'h0f80);
		rdc(iscs_pkg::OFF_STAT0, 32'h3);
		rdc(iscs_pkg::OFF_STAT1, {16'h0, pec_value, 8'hf7});
		rdc(iscs_pkg::OFF_STAT0, 32'h1);
		b = 8'($urandom);
		apb(1'b1, iscs_pkg::OFF_DATA, {24'h0, b});
		@(posedge pclk);
		chk({data_wr, data_wr_value}, {1'b1, b});
		rdc(iscs_pkg::OFF_STAT0, 32'h0);
		i_iscs_bus_model.stop_c();
		rdc(iscs_pkg::OFF_STAT1, {16'h0, pec_value, 8'h00});
		// Arbitration loss drops the role and direction but not busy
		i_iscs_bus_model.start_c();
		pev(15'h6040);
		rdc(iscs_pkg::OFF_STAT1, {16'h0, pec_value, 8'h07});
		pev(15'h0020);
		rdc(iscs_pkg::OFF_STAT1, {16'h0, pec_value, 8'h02});
		rdc(iscs_pkg::OFF_STAT0, 32'h209);
		apb(1'b1, iscs_pkg::OFF_DATA, 32'h0);
		rdc(iscs_pkg::OFF_STAT0, 32'h200);
		apb(1'b1, iscs_pkg::OFF_STAT0, 32'h0);
		rdc(iscs_pkg::OFF_STAT0, 32'h0);
		pev(15'h001a);
		rdc(iscs_pkg::OFF_STAT0, 32'h4);
		rdc(iscs_pkg::OFF_DATA, {24'h0, data_rd_value});
		@(posedge pclk);
		chk(data_rd, 1'b1);
		rdc(iscs_pkg::OFF_STAT0, 32'h0);
		pev(15'h0005);
		rdc(iscs_pkg::OFF_STAT0, 32'h4);
		i_iscs_bus_model.start_c();
		rdc(iscs_pkg::OFF_STAT0, 32'h0);
		apb(1'b1, iscs_pkg::OFF_CTL0, 32'ha1);
		pev(15'h001a);
		rdc(iscs_pkg::OFF_STAT0, 32'h0);
		apb(1'b1, iscs_pkg::OFF_CTL0, 32'h21);
		pev(15'h4880);
		apb(1'b1, iscs_pkg::OFF_CTL0, 32'h20);
		rdc(iscs_pkg::OFF_STAT0, 32'h0);
		apb(1'b0, iscs_pkg::OFF_STAT1, 32'h0);
		chk(rd & 32'hfd, 32'h0);
		apb(1'b1, iscs_pkg::OFF_SAMCS, 32'hf3);
		rdc(iscs_pkg::OFF_SAMCS, 32'h3f3);
		chk({cfg.frame_en, cfg.frame_timeout_en}, 2'b11);
		for (int i = 0; i < 4; i++)
		begin
			fl = 32'h1 << (i == 0 ? 14 : i == 1 ? 15 : i == 2 ? 12 : 13);
			lv = {22'h0, i != 0, i != 2, 8'h00};
			ie = fl >> 8;
			apb(1'b1, iscs_pkg::OFF_SAMCS, 32'hf3 & ~ie);
			i_iscs_bus_model.set_fr(i != 0, i != 2);
			repeat (6) @(posedge pclk);
			chk(irq, 1'b0);
			rdc(iscs_pkg::OFF_SAMCS, fl | lv | (32'hf3 & ~ie));
			apb(1'b1, iscs_pkg::OFF_SAMCS, fl | 32'hf3);
			repeat (2) @(posedge pclk);
			chk(irq, 1'b1);
			apb(1'b1, iscs_pkg::OFF_SAMCS, 32'hf3);
			rdc(iscs_pkg::OFF_SAMCS, lv | 32'hf3);
			chk(irq, 1'b0);
		end
		repeat (int'(iscs_pkg::FRAME_TIMEOUT_CYC) + 100) @(posedge pclk);
		chk(frame_timeout, 1'b1);
		end_of_test();
	end
endmodule : test_i2c_status_clock_sam_regs
